// [core/aux_control_dual_pointer.sv]
// auxiliary control register, dual data pointers and code-space reads
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module aux_control_dual_pointer #(
  parameter logic [7:0] SIG_BYTE_0    = 8'h5a, // arbitrary value
  parameter logic [7:0] SIG_BYTE_1    = 8'h3c, // arbitrary value
  parameter logic [7:0] SIG_BYTE_2    = 8'h96, // arbitrary value
  parameter int         CUSTOMER_SIZE = 32
) (
  input  wire logic                               ref_clk,
  input  wire logic                               rst,
  input  wire logic [aux_control_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                               s_axi_awvalid,
  output logic                                    s_axi_awready,
  input  wire logic [31:0]                        s_axi_wdata,
  input  wire logic [3:0]                         s_axi_wstrb,
  input  wire logic                               s_axi_wvalid,
  output logic                                    s_axi_wready,
  output logic [1:0]                              s_axi_bresp,
  output logic                                    s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  input  wire logic [aux_control_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                               s_axi_arvalid,
  output logic                                    s_axi_arready,
  output logic [31:0]                             s_axi_rdata,
  output logic [1:0]                              s_axi_rresp,
  output logic                                    s_axi_rvalid,
  input  wire logic                               s_axi_rready,
  output logic                                    chipReset,
  output logic [15:0]                             fetchAddr,
  output logic                                    brownoutEnable,
  input  wire logic                               progMode,
  input  wire logic                               progClk,
  input  wire logic                               progDataIn,
  output logic                                    progDataOut,
  output logic                                    progDataOeN
);
  import aux_control_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]              auxControl;
  logic [15:0]             pointer [2];
  logic                    softResetPending;
  logic                    sfrReset;
  logic [7:0]              resultByte;
  logic [7:0]              customerArea [CUSTOMER_SIZE];
  logic [7:0]              configOne;
  logic                    awHeld;
  logic                    wHeld;
  logic [ADDR_W-1:0]       awAddr;
  logic [31:0]             wData;
  logic [3:0]              wStrb;
  logic                    doWrite;
  logic                    writeHit;
  logic                    sel;
  logic [15:0]             selPointer;
  logic [2:0]              cmdOp;
  logic [7:0]              cmdAcc;
  logic [15:0]             cmdAddr;
  logic [7:0]              codeByte;
  logic [7:0]              extByte;
  logic                    progClkPrev;
  logic                    progRise;
  logic [5:0]              progCount;
  logic [7:0]              progCmd;
  logic [15:0]             progAddr;
  logic [7:0]              progShift;

  // ---------------------------------------------------------------
  // soft reset
  // ---------------------------------------------------------------
  // the bit is never stored, so it reads zero after the reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      softResetPending <= 1'b0;
    end else begin
      softResetPending <= doWrite && awAddr == AUX_CONTROL_ADDR &&
                          wStrb[0] && wData[SOFT_RESET_BIT];
    end
  end

  assign sfrReset  = rst || softResetPending;
  assign chipReset = sfrReset;

  // ---------------------------------------------------------------
  // bus write side
  // ---------------------------------------------------------------
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign doWrite       = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awHeld <= 1'b0;
      awAddr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wHeld <= 1'b0;
      wData <= '0;
      wStrb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  assign writeHit = awAddr == AUX_CONTROL_ADDR || awAddr == PTR_LOW_ADDR ||
                    awAddr == PTR_HIGH_ADDR || awAddr == COMMAND_ADDR;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= writeHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // aux control register
  // ---------------------------------------------------------------
  assign cmdOp   = wData[2:0];
  assign cmdAcc  = wData[15:8];
  assign sel     = auxControl[SELECT_BIT];

  // an increment flips the select only: the carry must not reach bit 1
  always_ff @(posedge ref_clk) begin
    if (sfrReset) begin
      auxControl <= AUX_CONTROL_RESET;
    end else if (doWrite && awAddr == AUX_CONTROL_ADDR && wStrb[0]) begin
      auxControl <= wData[7:0] & AUX_STORED_MASK;
    end else if (doWrite && awAddr == COMMAND_ADDR && wStrb[0] &&
                 cmdOp == OP_INC_AUX) begin
      auxControl[SELECT_BIT] <= !auxControl[SELECT_BIT];
    end
  end

  assign brownoutEnable = !auxControl[BROWNOUT_OFF_BIT];

  // ---------------------------------------------------------------
  // dual data pointers
  // ---------------------------------------------------------------
  assign selPointer = pointer[sel];
  assign cmdAddr    = selPointer + {8'h00, cmdAcc};

  for (genvar i = 0; i < 2; i++) begin : g_pointer
    always_ff @(posedge ref_clk) begin
      if (sfrReset) begin
        pointer[i] <= 16'h0000;
      end else if (doWrite && sel == 1'(i)) begin
        if (awAddr == PTR_LOW_ADDR && wStrb[0]) begin
          pointer[i][7:0] <= wData[7:0];
        end else if (awAddr == PTR_HIGH_ADDR && wStrb[0]) begin
          pointer[i][15:8] <= wData[7:0];
        end else if (awAddr == COMMAND_ADDR && wStrb[0]) begin
          if (cmdOp == OP_INC_POINTER) begin
            pointer[i] <= pointer[i] + 16'h0001;
          end else if (cmdOp == OP_LOAD_POINTER && wStrb[3:2] == 2'b11) begin
            pointer[i] <= wData[31:16];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // code and external reads
  // ---------------------------------------------------------------
  // main program memory lies outside this block and reads erased
  always_comb begin
    codeByte = ERASED_BYTE;
    if (cmdAddr == SIG_ADDR_0) begin
      codeByte = SIG_BYTE_0;
    end else if (cmdAddr == SIG_ADDR_1) begin
      codeByte = SIG_BYTE_1;
    end else if (cmdAddr == SIG_ADDR_2) begin
      codeByte = SIG_BYTE_2;
    end else if (cmdAddr >= CUSTOMER_BASE && cmdAddr <= CUSTOMER_LAST) begin
      codeByte = customerArea[cmdAddr[4:0]];
    end
  end

  // no external data bus: only the configuration byte answers
  always_comb begin
    extByte = 8'h00;
    if (selPointer == CONFIG_ONE_ADDR) begin
      extByte = configOne;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sfrReset) begin
      resultByte <= 8'h00;
    end else if (doWrite && awAddr == COMMAND_ADDR && wStrb[0]) begin
      if (cmdOp == OP_CODE_READ) begin
        resultByte <= codeByte;
      end else if (cmdOp == OP_EXT_READ) begin
        resultByte <= extByte;
      end
    end
  end

  // ---------------------------------------------------------------
  // instruction fetch address
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sfrReset) begin
      fetchAddr <= FETCH_RESET_ADDR;
    end else if (doWrite && awAddr == COMMAND_ADDR && wStrb[0] &&
                 cmdOp == OP_JUMP) begin
      fetchAddr <= cmdAddr;
    end
  end

  // ---------------------------------------------------------------
  // bus read side
  // ---------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr)
        AUX_CONTROL_ADDR: begin
          s_axi_rdata <= {24'h0, auxControl};
        end
        PTR_LOW_ADDR: begin
          s_axi_rdata <= {24'h0, selPointer[7:0]};
        end
        PTR_HIGH_ADDR: begin
          s_axi_rdata <= {24'h0, selPointer[15:8]};
        end
        COMMAND_ADDR: begin
          s_axi_rdata <= 32'h0;
        end
        RESULT_ADDR: begin
          s_axi_rdata <= {24'h0, resultByte};
        end
        STATUS_ADDR: begin
          s_axi_rdata <= {fetchAddr, selPointer};
        end
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // two-pin serial programming
  // ---------------------------------------------------------------
  // frame: 8 command bits, 16 address bits, 8 data bits, msb first;
  // the customer bytes survive both resets; the configuration byte survives only the soft reset
  assign progRise = progClk && !progClkPrev;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      progClkPrev <= 1'b0;
    end else begin
      progClkPrev <= progClk;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !progMode) begin
      progCount   <= '0;
      progCmd     <= '0;
      progAddr    <= '0;
      progShift   <= '0;
      progDataOeN <= 1'b1;
      progDataOut <= 1'b0;
    end else if (progRise && progCount != PROG_FRAME_DONE) begin
      progCount <= progCount + 6'd1;
      if (progCount < 6'd8) begin
        progCmd <= {progCmd[6:0], progDataIn};
      end else if (progCount < PROG_ADDR_DONE) begin
        progAddr <= {progAddr[14:0], progDataIn};
      end else begin
        progShift <= {progShift[6:0], progDataIn};
      end
      if (progCount == PROG_ADDR_DONE - 6'd1 && progCmd == PROG_CMD_READ) begin
        progDataOeN <= 1'b0;
      end else if (progCount == PROG_FRAME_DONE - 6'd1) begin
        progDataOeN <= 1'b1;
      end
    end else if (progDataOeN == 1'b0) begin
      progDataOut <= progReadBit(progAddr, 3'd7 - progCount[2:0]);
    end
  end

  function automatic logic progReadBit(input logic [15:0] a,
                                       input logic [2:0]  n);
    logic [7:0] v;
    v = ERASED_BYTE;
    if (a == SIG_ADDR_0) begin
      v = SIG_BYTE_0;
    end else if (a == SIG_ADDR_1) begin
      v = SIG_BYTE_1;
    end else if (a == SIG_ADDR_2) begin
      v = SIG_BYTE_2;
    end else if (a >= CUSTOMER_BASE && a <= CUSTOMER_LAST) begin
      v = customerArea[a[4:0]];
    end else if (a == CONFIG_ONE_ADDR) begin
      v = configOne;
    end
    return v[n];
  endfunction

  // programmed together with the main code space, one byte per frame
  always_ff @(posedge ref_clk) begin
    if (progMode && progRise && progCount == PROG_FRAME_DONE - 6'd1 &&
        progCmd == PROG_CMD_WRITE) begin
      if (progAddr >= CUSTOMER_BASE && progAddr <= CUSTOMER_LAST) begin
        customerArea[progAddr[4:0]] <= {progShift[6:0], progDataIn};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      configOne <= ERASED_BYTE;
    end else if (progMode && progRise && progCount == PROG_FRAME_DONE - 6'd1 &&
                 progCmd == PROG_CMD_WRITE && progAddr == CONFIG_ONE_ADDR) begin
      configOne <= {progShift[6:0], progDataIn};
    end
  end

endmodule

`default_nettype wire

// [core/aux_control_pkg.sv]
// constants shared by the auxiliary control and dual pointer block
package aux_control_pkg;

  // ---------------------------------------------------------------
  // register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0]  AUX_CONTROL_INDEX  = 8'ha2;
  localparam logic [7:0]  PTR_LOW_INDEX      = 8'h82;
  localparam logic [7:0]  PTR_HIGH_INDEX     = 8'h83;
  localparam int          ADDR_W             = 12;
  localparam logic [11:0] AUX_CONTROL_ADDR   = {2'h0, AUX_CONTROL_INDEX, 2'h0};
  localparam logic [11:0] PTR_LOW_ADDR       = {2'h0, PTR_LOW_INDEX, 2'h0};
  localparam logic [11:0] PTR_HIGH_ADDR      = {2'h0, PTR_HIGH_INDEX, 2'h0};
  localparam logic [11:0] COMMAND_ADDR       = 12'h300;
  localparam logic [11:0] RESULT_ADDR        = 12'h304;
  localparam logic [11:0] STATUS_ADDR        = 12'h308;

  // ---------------------------------------------------------------
  // aux control fields
  // ---------------------------------------------------------------
  localparam logic [7:0] AUX_CONTROL_RESET  = 8'h00;
  localparam int         SELECT_BIT         = 0;
  localparam int         ZERO_BIT           = 2;
  localparam int         SOFT_RESET_BIT     = 3;
  localparam int         BROWNOUT_OFF_BIT   = 6;
  localparam logic [7:0] AUX_STORED_MASK    = 8'hf3;

  // ---------------------------------------------------------------
  // command register fields and opcodes
  // ---------------------------------------------------------------
  localparam logic [2:0] OP_INC_POINTER     = 3'h1;
  localparam logic [2:0] OP_LOAD_POINTER    = 3'h2;
  localparam logic [2:0] OP_CODE_READ       = 3'h3;
  localparam logic [2:0] OP_EXT_READ        = 3'h4;
  localparam logic [2:0] OP_JUMP            = 3'h5;
  localparam logic [2:0] OP_INC_AUX         = 3'h6;

  // ---------------------------------------------------------------
  // code and configuration space
  // ---------------------------------------------------------------
  localparam logic [15:0] SIG_ADDR_0        = 16'hfc30;
  localparam logic [15:0] SIG_ADDR_1        = 16'hfc31;
  localparam logic [15:0] SIG_ADDR_2        = 16'hfc60;
  localparam logic [15:0] CUSTOMER_BASE     = 16'hfce0;
  localparam logic [15:0] CUSTOMER_LAST     = 16'hfcff;
  localparam logic [15:0] CONFIG_ONE_ADDR   = 16'hfd00;
  localparam logic [15:0] FETCH_RESET_ADDR  = 16'h0000;
  localparam logic [7:0]  ERASED_BYTE       = 8'hff;

  // ---------------------------------------------------------------
  // serial programming frame
  // ---------------------------------------------------------------
  localparam logic [7:0] PROG_CMD_WRITE     = 8'h01;
  localparam logic [7:0] PROG_CMD_READ      = 8'h02;
  localparam logic [5:0] PROG_ADDR_DONE     = 6'd24;
  localparam logic [5:0] PROG_FRAME_DONE    = 6'd32;

  localparam logic [1:0] RESP_OKAY          = 2'b00;
  localparam logic [1:0] RESP_SLVERR        = 2'b10;

endpackage

// [verification/aux_control_dual_pointer_assertions.sv]
// concurrent checks on the auxiliary control block ports
`timescale 1ns/1ps
`default_nettype none

module aux_control_dual_pointer_assertions
  import aux_control_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              chipReset,
  input wire logic [15:0]       fetchAddr,
  input wire logic              brownoutEnable,
  input wire logic              progMode,
  input wire logic              progDataOeN
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ------
  // write steps
  // ------
  sequence wrBoth;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence softWr;
    wrBoth ##0 (s_axi_awaddr == AUX_CONTROL_ADDR && s_axi_wstrb[0]
                && s_axi_wdata[SOFT_RESET_BIT]);
  endsequence

  AST_WRITE_RESP: assert property (wrBoth |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  AST_SOFT_RESET: assert property (softWr |-> ##[1:4] chipReset)
    else $error("soft reset write gave no chip reset");
  AST_RESET_PULSE: assert property (chipReset |=> !chipReset)
    else $error("soft reset repeated");
  AST_RESET_STATE: assert property (
    chipReset |=> fetchAddr == FETCH_RESET_ADDR && brownoutEnable)
    else $error("state not cleared by reset");
  AST_BROWNOUT: assert property (
    $changed(brownoutEnable) |-> $rose(s_axi_bvalid) || $past(chipReset))
    else $error("brownout changed without a write");
  AST_FETCH: assert property (
    $changed(fetchAddr) |-> $rose(s_axi_bvalid) || $past(chipReset))
    else $error("fetch address moved without cause");
  AST_BVALID_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  AST_READ_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_RVALID_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  AST_LINK_IDLE: assert property (!progMode ##1 !progMode |-> progDataOeN)
    else $error("data pin driven outside programming");
endmodule

bind aux_control_dual_pointer aux_control_dual_pointer_assertions chk (
  .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .chipReset(chipReset), .fetchAddr(fetchAddr),
  .brownoutEnable(brownoutEnable), .progMode(progMode),
  .progDataOeN(progDataOeN));

`default_nettype wire

// [verification/aux_control_dual_pointer_tb.sv]
// self-checking bench for the auxiliary control block
`timescale 1ns/1ps
`default_nettype none

module aux_control_dual_pointer_tb;
  import aux_control_pkg::*;
  localparam logic [7:0] SIG0 = 8'h5a; // arbitrary value
  localparam logic [7:0] SIG1 = 8'h3c; // arbitrary value
  localparam logic [7:0] SIG2 = 8'h96; // arbitrary value
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata, rv;
  logic [3:0]        s_axi_wstrb = '0;
  logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic              s_axi_arvalid = 0, s_axi_rready = 0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, resp;
  logic              progMode = 0, progClk = 0, progDrive = 0, progDataIn;
  logic              chipReset, brownoutEnable, progDataOut, progDataOeN;
  logic [15:0]       fetchAddr;
  logic [7:0]        linkByte;
  logic [15:0]       sa [3] = '{SIG_ADDR_0, SIG_ADDR_1, SIG_ADDR_2};
  logic [7:0]        sb [3] = '{SIG0, SIG1, SIG2};
  int                n_fail = 0;
  int                n_tests = 0;
  int                nPulse = 0;

  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (chipReset && !rst) nPulse <= nPulse + 1;
  // shared pin: the device wins while it drives
  assign progDataIn = progDataOeN ? progDrive : progDataOut;

  aux_control_dual_pointer #(.SIG_BYTE_0(SIG0), .SIG_BYTE_1(SIG1),
    .SIG_BYTE_2(SIG2), .CUSTOMER_SIZE(32)) dut (
    .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .chipReset(chipReset), .fetchAddr(fetchAddr),
    .brownoutEnable(brownoutEnable), .progMode(progMode),
    .progClk(progClk), .progDataIn(progDataIn),
    .progDataOut(progDataOut), .progDataOeN(progDataOeN));

  // ------
  // access tasks
  // ------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // valids sampled mid-cycle so the edge decision never races the design
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic ah, wh, bh;
    bh = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int t = 0; t < 64 && !bh; t++) begin
      @(negedge ref_clk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge ref_clk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk("write answered", 32'(bh), 32'h1);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [31:0] exp, input logic [31:0] mask);
    logic ah, rh;
    rh = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int t = 0; t < 64 && !rh; t++) begin
      @(negedge ref_clk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      rv = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge ref_clk);
      if (ah) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(nm, rv & mask, exp);
  endtask

  task automatic cmd(input logic [2:0] op, input logic [7:0] acc,
                     input logic [15:0] imm);
    wr(COMMAND_ADDR, {imm, acc, 5'h0, op}, 4'hf);
  endtask

  // three ref_clk low and two high per link bit, reply bits caught before each rise
  task automatic link(input logic [31:0] f);
    @(posedge ref_clk);
    progMode <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      @(posedge ref_clk);
      progDrive <= f[31-i];
      @(posedge ref_clk);
      @(negedge ref_clk);
      if (i >= 24) linkByte = {linkByte[6:0], progDataOut};
      @(posedge ref_clk);
      progClk <= 1'b1;
      repeat (2) @(posedge ref_clk);
      progClk <= 1'b0;
    end
    repeat (3) @(posedge ref_clk);
    progMode <= 1'b0;
  endtask

  task print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    print_verdict();
  end

  // ------
  // scenarios
  // ------
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rdc("aux reset", AUX_CONTROL_ADDR, 32'h0, 32'hff);
    chk("brownout on", 32'(brownoutEnable), 32'h1);
    wr(AUX_CONTROL_ADDR, 32'hf5, 4'h1);
    rdc("aux zero bit", AUX_CONTROL_ADDR, 32'hf1, 32'hff);
    chk("brownout off", 32'(brownoutEnable), 32'h0);
    wr(PTR_LOW_ADDR, 32'h78, 4'h1);
    wr(PTR_HIGH_ADDR, 32'h56, 4'h1);
    wr(AUX_CONTROL_ADDR, 32'h40, 4'h1);
    wr(PTR_LOW_ADDR, 32'h34, 4'h1);
    wr(PTR_HIGH_ADDR, 32'h12, 4'h1);
    rdc("pointer high", PTR_HIGH_ADDR, 32'h12, 32'hff);
    rdc("pointer zero", STATUS_ADDR, 32'h1234, 32'hffff);
    cmd(OP_INC_AUX, 8'h0, 16'h0);
    rdc("aux increment", AUX_CONTROL_ADDR, 32'h41, 32'hff);
    rdc("pointer one", STATUS_ADDR, 32'h5678, 32'hffff);
    cmd(OP_INC_AUX, 8'h0, 16'h0);
    rdc("aux toggle back", AUX_CONTROL_ADDR, 32'h40, 32'hff);
    wr(AUX_CONTROL_ADDR, 32'h40, 4'h1);
    wr(PTR_LOW_ADDR, 32'hff, 4'h2);
    rdc("strobe ignored", PTR_LOW_ADDR, 32'h34, 32'hff);
    wr(PTR_LOW_ADDR, 32'hff, 4'h1);
    cmd(OP_INC_POINTER, 8'h0, 16'h0);
    rdc("increment carry", STATUS_ADDR, 32'h1300, 32'hffff);
    for (int k = 0; k < 3; k++) begin
      cmd(OP_LOAD_POINTER, 8'h0, sa[k]);
      cmd(OP_CODE_READ, 8'h0, 16'h0);
      rdc("signature", RESULT_ADDR, 32'(sb[k]), 32'hff);
    end
    cmd(OP_LOAD_POINTER, 8'h0, CUSTOMER_BASE);
    link({PROG_CMD_WRITE, 16'hfce5, 8'ha5});
    cmd(OP_CODE_READ, 8'h05, 16'h0);
    rdc("customer byte", RESULT_ADDR, 32'ha5, 32'hff);
    link({PROG_CMD_READ, 16'hfce5, 8'h00});
    chk("link read", 32'(linkByte), 32'ha5);
    link({PROG_CMD_WRITE, CONFIG_ONE_ADDR, 8'hc3});
    cmd(OP_LOAD_POINTER, 8'h0, CONFIG_ONE_ADDR);
    cmd(OP_EXT_READ, 8'h0, 16'h0);
    rdc("config byte", RESULT_ADDR, 32'hc3, 32'hff);
    cmd(OP_CODE_READ, 8'h0, 16'h0);
    rdc("config not code", RESULT_ADDR, 32'hff, 32'hff);
    cmd(OP_JUMP, 8'h03, 16'h0);
    chk("jump target", 32'(fetchAddr), 32'hfd03);
    wr(AUX_CONTROL_ADDR, 32'h41, 4'h1);
    rdc("other kept", STATUS_ADDR, 32'hfd035678, 32'hffffffff);
    wr(12'h004, 32'h1, 4'hf);
    chk("unmapped write", 32'(resp), 32'(RESP_SLVERR));
    rdc("unmapped read", 12'h004, 32'h0, 32'hffffffff);
    chk("unmapped resp", 32'(resp), 32'(RESP_SLVERR));
    wr(AUX_CONTROL_ADDR, 32'h48, 4'h1);
    chk("soft reset answer", 32'(resp), 32'(RESP_OKAY));
    repeat (3) @(posedge ref_clk);
    chk("soft reset pulses", 32'(nPulse), 32'h1);
    rdc("aux after reset", AUX_CONTROL_ADDR, 32'h0, 32'hff);
    rdc("state after reset", STATUS_ADDR, 32'h0, 32'hffffffff);
    chk("brownout after", 32'(brownoutEnable), 32'h1);
    print_verdict();
  end
endmodule

`default_nettype wire
